//--- logic/fault_rec_pkg.sv
// Shared constants, record layout and state encoding of the fault event recorder
package fault_rec_pkg;

    // ----------------------------------------------------------------
    // Widths and store size
    // ----------------------------------------------------------------
    localparam int unsigned REC_DEPTH = 20;
    localparam int unsigned PTR_W = 5;
    localparam int unsigned MOD_W = 4;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned TIME_W = 32;
    localparam int unsigned MEAS_W = 32;
    localparam int unsigned SET_W = 2;
    localparam int unsigned ADAPT_W = 4;
    localparam int unsigned DLY_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // ----------------------------------------------------------------
    // Timing: durations are counted in ticks of 1 us
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned TICK_PS = 1000000;
    localparam int unsigned TICK_CYCLES = TICK_PS / CLK_PERIOD_PS;
    localparam int unsigned TICK_W = 8;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DELAY = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SEL = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_NUMBERS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DURATION = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_TTT = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_INFO = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_STAMP = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_MEAS = 8'h24;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int unsigned CTRL_MODE_BIT = 0;
    localparam int unsigned STAT_NEW_BIT = 0;
    localparam int unsigned STAT_ACTIVE_BIT = 1;
    localparam int unsigned STAT_COUNT_LSB = 8;
    localparam logic MODE_RST = 1'b1;
    localparam logic [DLY_W-1:0] DELAY_RST = 16'h0000;

    // ----------------------------------------------------------------
    // Record layout and control states
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [TIME_W-1:0] stamp;
        logic [CNT_W-1:0] fault_no;
        logic [CNT_W-1:0] grid_no;
        logic [TIME_W-1:0] duration;
        logic [TIME_W-1:0] ttt;
        logic ttt_valid;
        logic tripped;
        logic [MOD_W-1:0] pick_id;
        logic [MOD_W-1:0] trip_id;
        logic [SET_W-1:0] param_set;
        logic adapt_valid;
        logic [ADAPT_W-1:0] adapt_set;
        logic [MEAS_W-1:0] meas;
    } rec_s;

    localparam int unsigned INFO_W = 2 + 2 * MOD_W + SET_W + 1 + ADAPT_W;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACTIVE = 2'b01,
        ST_WAIT = 2'b11,
        ST_COMMIT = 2'b10
    } fsm_e;

endpackage

//--- logic/rec_store.sv
// Record store: simple dual-port memory with registered read data
`timescale 1ns/1ps
module rec_store #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 20,
    parameter int unsigned AW = 5
) (
    // Clock
    input wire logic core_clk_i,
    // Write port
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    // Read port
    input wire logic [AW-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);

    logic [WIDTH-1:0] mem [DEPTH];

    // No reset on the array: older records are volatile by nature
    always_ff @(posedge core_clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end

endmodule // rec_store

//--- logic/fault_event_recorder.sv
// Fault event recorder: fault capture, record store and APB register slave
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps

// Notes on behaviour
// - A new record starts when the combined pickup rises.
// - Combined pickup is the OR of all module pickups.
// - Combined trip is the OR of all module trips.
// - Measurements are snapshot at the first trip decision.
// - A nonzero capture delay postpones the snapshot by that delay.
// - Alarms-and-trips mode stores every fault, tripped or not.
// - Trips-only mode drops faults that never tripped.
// - New-fault notice rises at a kept commit, after pickup fall and any delayed snapshot; sel keeps its value, so the newest record is presented only at sel 0.
// - The store holds at most 20 records.
// - A full store overwrites its oldest record first.
// - The newest record is also held in a fail-safe copy.
// - Duration runs from combined pickup rise to its fall.
// - Time to trip runs from first pickup to first trip.
// - Time to trip is invalid when pickup and trip modules differ.
// - Fault number increments on each fault and is recorded.
// - Grid-fault number increments too, except during auto-reclose.
// - Record holds the module that picked up first.
// - Record holds the module that tripped first.
// - Record holds time stamp, parameter set and adaptive set.
// - Record holds a flag telling whether the fault tripped.
// - Record holds measured values from the snapshot point.
module fault_event_recorder #(
    parameter int unsigned N_PROT = 8
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [fault_rec_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [fault_rec_pkg::DATA_W-1:0] pwdata_i,
    output logic pready_o,
    output logic [fault_rec_pkg::DATA_W-1:0] prdata_o,
    output logic pslverr_o,
    // Protection modules
    input wire logic [N_PROT-1:0] pickup_i,
    input wire logic [N_PROT-1:0] trip_i,
    input wire logic auto_reclose_i,
    // Context and measurements
    input wire logic [fault_rec_pkg::TIME_W-1:0] time_stamp_i,
    input wire logic [fault_rec_pkg::SET_W-1:0] param_set_i,
    input wire logic adaptive_en_i,
    input wire logic [fault_rec_pkg::ADAPT_W-1:0] active_adaptive_set_i,
    input wire logic [fault_rec_pkg::MEAS_W-1:0] meas_i,
    // Display
    output logic new_fault_o,
    output logic fault_active_o
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    function automatic logic [fault_rec_pkg::MOD_W-1:0] first_index(
        input logic [N_PROT-1:0] v);
        logic [fault_rec_pkg::MOD_W-1:0] idx;
        idx = '0;
        for (int i = N_PROT - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = fault_rec_pkg::MOD_W'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [fault_rec_pkg::TIME_W-1:0] sat_inc(
        input logic [fault_rec_pkg::TIME_W-1:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction

    function automatic logic [fault_rec_pkg::PTR_W-1:0] ptr_inc(
        input logic [fault_rec_pkg::PTR_W-1:0] p);
        logic [fault_rec_pkg::PTR_W-1:0] r;
        r = p + 1'b1;
        if (p == fault_rec_pkg::PTR_W'(fault_rec_pkg::REC_DEPTH - 1)) begin
            r = '0;
        end
        return r;
    endfunction

    // Slot holding the record that lies sel places behind the newest
    function automatic logic [fault_rec_pkg::PTR_W-1:0] slot_of(
        input logic [fault_rec_pkg::PTR_W-1:0] wr,
        input logic [fault_rec_pkg::PTR_W-1:0] sel);
        logic [fault_rec_pkg::PTR_W:0] t;
        t = {1'b0, wr} + (fault_rec_pkg::PTR_W + 1)'(fault_rec_pkg::REC_DEPTH - 1)
            - {1'b0, sel};
        if (t >= (fault_rec_pkg::PTR_W + 1)'(fault_rec_pkg::REC_DEPTH)) begin
            t = t - (fault_rec_pkg::PTR_W + 1)'(fault_rec_pkg::REC_DEPTH);
        end
        return t[fault_rec_pkg::PTR_W-1:0];
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        fault_rec_pkg::fsm_e fsm;
        logic mode;
        logic [fault_rec_pkg::DLY_W-1:0] dly;
        logic [fault_rec_pkg::PTR_W-1:0] sel;
        logic new_fault;
        logic [fault_rec_pkg::TICK_W-1:0] tick_cnt;
        logic tick;
        logic [fault_rec_pkg::CNT_W-1:0] fault_no;
        logic [fault_rec_pkg::CNT_W-1:0] grid_no;
        fault_rec_pkg::rec_s cur;
        logic trip_seen;
        logic meas_wait;
        logic [fault_rec_pkg::DLY_W-1:0] dly_cnt;
        logic [fault_rec_pkg::PTR_W-1:0] wr_ptr;
        logic [fault_rec_pkg::PTR_W:0] count;
        fault_rec_pkg::rec_s nv;
        logic pready;
        logic [fault_rec_pkg::DATA_W-1:0] prdata;
        logic pslverr;
    } st_s;

    st_s s;
    st_s n;

    logic any_pickup;
    logic any_trip;
    logic keep;
    logic mem_we;
    fault_rec_pkg::rec_s mem_rdata;
    fault_rec_pkg::rec_s rsel;
    logic [fault_rec_pkg::MOD_W-1:0] trip_idx;

    assign any_pickup = |pickup_i;
    assign any_trip = |trip_i;
    assign trip_idx = first_index(trip_i);
    assign keep = s.mode | s.cur.tripped;
    assign mem_we = (s.fsm == fault_rec_pkg::ST_COMMIT) && keep;
    // Slot 0 comes from the fail-safe copy, a register that reset clears with the rest of the state
    assign rsel = (s.sel == '0) ? s.nv : mem_rdata;

    // ----------------------------------------------------------------
    // Record store
    // ----------------------------------------------------------------
    rec_store #(
        .WIDTH($bits(fault_rec_pkg::rec_s)),
        .DEPTH(fault_rec_pkg::REC_DEPTH),
        .AW(fault_rec_pkg::PTR_W)
    ) u_store (
        .core_clk_i(core_clk_i),
        .we_i(mem_we),
        .waddr_i(s.wr_ptr),
        .wdata_i(s.cur),
        .raddr_i(slot_of(s.wr_ptr, s.sel)),
        .rdata_o(mem_rdata)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        n = s;

        // Microsecond tick for all time measurements
        n.tick = 1'b0;
        n.tick_cnt = s.tick_cnt + 1'b1;
        if (s.tick_cnt == fault_rec_pkg::TICK_W'(fault_rec_pkg::TICK_CYCLES - 1)) begin
            n.tick_cnt = '0;
            n.tick = 1'b1;
        end

        case (s.fsm)
            fault_rec_pkg::ST_IDLE: begin
                // Idle implies pickup was low since the last commit, so a high level is a rise
                if (any_pickup) begin
                    n.fsm = fault_rec_pkg::ST_ACTIVE;
                    n.fault_no = s.fault_no + 1'b1;
                    if (!auto_reclose_i) begin
                        n.grid_no = s.grid_no + 1'b1;
                    end
                    n.cur = '0;
                    n.cur.fault_no = n.fault_no;
                    n.cur.grid_no = n.grid_no;
                    n.cur.stamp = time_stamp_i;
                    n.cur.param_set = param_set_i;
                    n.cur.adapt_valid = adaptive_en_i;
                    n.cur.adapt_set = adaptive_en_i ? active_adaptive_set_i : '0;
                    n.cur.pick_id = first_index(pickup_i);
                    n.trip_seen = 1'b0;
                    n.meas_wait = 1'b0;
                end
            end
            fault_rec_pkg::ST_ACTIVE: begin
                if (s.tick) begin
                    n.cur.duration = sat_inc(s.cur.duration);
                    if (!s.trip_seen) begin
                        n.cur.ttt = sat_inc(s.cur.ttt);
                    end
                end
                if (any_trip && !s.trip_seen) begin
                    n.trip_seen = 1'b1;
                    n.cur.tripped = 1'b1;
                    n.cur.trip_id = trip_idx;
                    n.cur.ttt_valid = (trip_idx == s.cur.pick_id);
                    if (s.dly == '0) begin
                        n.cur.meas = meas_i;
                    end else begin
                        n.meas_wait = 1'b1;
                        n.dly_cnt = s.dly;
                    end
                end
                if (!any_pickup) begin
                    n.fsm = n.meas_wait ? fault_rec_pkg::ST_WAIT : fault_rec_pkg::ST_COMMIT;
                end
            end
            fault_rec_pkg::ST_WAIT: begin
                if (!s.meas_wait) begin
                    n.fsm = fault_rec_pkg::ST_COMMIT;
                end
            end
            fault_rec_pkg::ST_COMMIT: begin
                n.fsm = fault_rec_pkg::ST_IDLE;
                if (keep) begin
                    n.wr_ptr = ptr_inc(s.wr_ptr);
                    n.nv = s.cur;
                    n.new_fault = 1'b1;
                    if (s.count < (fault_rec_pkg::PTR_W + 1)'(fault_rec_pkg::REC_DEPTH)) begin
                        n.count = s.count + 1'b1;
                    end
                end
            end
            default: begin
                n.fsm = fault_rec_pkg::ST_IDLE;
            end
        endcase

        // Delayed snapshot may still be pending after pickup has dropped
        if (s.meas_wait && s.fsm != fault_rec_pkg::ST_IDLE) begin
            if (s.dly_cnt == '0) begin
                n.cur.meas = meas_i;
                n.meas_wait = 1'b0;
            end else if (s.tick) begin
                n.dly_cnt = s.dly_cnt - 1'b1;
            end
        end

        // APB: one wait state gives the store a cycle to read
        n.pready = psel_i && penable_i && !s.pready;
        n.pslverr = 1'b0;
        if (psel_i && penable_i && !s.pready) begin
            n.prdata = '0;
            n.pslverr = 1'b0;
            case (paddr_i)
                fault_rec_pkg::OFS_CTRL: n.prdata[fault_rec_pkg::CTRL_MODE_BIT] = s.mode;
                fault_rec_pkg::OFS_DELAY: n.prdata = fault_rec_pkg::DATA_W'(s.dly);
                fault_rec_pkg::OFS_STATUS: begin
                    n.prdata[fault_rec_pkg::STAT_NEW_BIT] = s.new_fault;
                    n.prdata[fault_rec_pkg::STAT_ACTIVE_BIT] = s.fsm[0];
                    n.prdata[fault_rec_pkg::STAT_COUNT_LSB +: fault_rec_pkg::PTR_W + 1] =
                        s.count;
                end
                fault_rec_pkg::OFS_SEL: n.prdata = fault_rec_pkg::DATA_W'(s.sel);
                fault_rec_pkg::OFS_NUMBERS: n.prdata = {rsel.grid_no, rsel.fault_no};
                fault_rec_pkg::OFS_DURATION: n.prdata = rsel.duration;
                fault_rec_pkg::OFS_TTT: n.prdata = rsel.ttt;
                fault_rec_pkg::OFS_INFO: n.prdata = fault_rec_pkg::DATA_W'({
                    rsel.adapt_valid, rsel.adapt_set, rsel.param_set,
                    rsel.trip_id, rsel.pick_id, rsel.tripped, rsel.ttt_valid});
                fault_rec_pkg::OFS_STAMP: n.prdata = rsel.stamp;
                fault_rec_pkg::OFS_MEAS: n.prdata = rsel.meas;
                default: n.pslverr = 1'b1;
            endcase
        end

        // Writes take effect at the edge where pready is sampled high
        if (psel_i && penable_i && s.pready && pwrite_i) begin
            case (paddr_i)
                fault_rec_pkg::OFS_CTRL: n.mode = pwdata_i[fault_rec_pkg::CTRL_MODE_BIT];
                fault_rec_pkg::OFS_DELAY: n.dly = pwdata_i[fault_rec_pkg::DLY_W-1:0];
                fault_rec_pkg::OFS_STATUS: begin
                    // A commit in the same cycle wins over the clear
                    if (pwdata_i[fault_rec_pkg::STAT_NEW_BIT] && !mem_we) begin
                        n.new_fault = 1'b0;
                    end
                end
                fault_rec_pkg::OFS_SEL: begin
                    if (pwdata_i[fault_rec_pkg::PTR_W-1:0] <
                        fault_rec_pkg::PTR_W'(fault_rec_pkg::REC_DEPTH)) begin
                        n.sel = pwdata_i[fault_rec_pkg::PTR_W-1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            s <= '0;
            s.mode <= fault_rec_pkg::MODE_RST;
            s.dly <= fault_rec_pkg::DELAY_RST;
        end else begin
            s <= n;
        end
    end

    assign pready_o = s.pready;
    assign prdata_o = s.prdata;
    assign pslverr_o = s.pslverr;
    assign new_fault_o = s.new_fault;
    assign fault_active_o = s.fsm[0];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    property p_start_on_pickup;
        (s.fsm == fault_rec_pkg::ST_IDLE) && any_pickup |=>
            (s.fsm == fault_rec_pkg::ST_ACTIVE) && (s.fault_no == $past(s.fault_no) + 1'b1)
            && (s.cur.fault_no == s.fault_no);
    endproperty
    a_start_on_pickup: assert property (p_start_on_pickup)
        else $error("fault did not start on pickup");

    property p_grid_hold;
        (s.fsm == fault_rec_pkg::ST_IDLE) && any_pickup && auto_reclose_i |=>
            s.grid_no == $past(s.grid_no);
    endproperty
    a_grid_hold: assert property (p_grid_hold)
        else $error("grid fault counted during auto-reclose");

    property p_trips_only;
        (s.fsm == fault_rec_pkg::ST_COMMIT) && !s.mode && !s.cur.tripped |=>
            (s.count == $past(s.count)) && (s.wr_ptr == $past(s.wr_ptr));
    endproperty
    a_trips_only: assert property (p_trips_only)
        else $error("untripped fault stored in trips-only mode");

    property p_alarm_store;
        (s.fsm == fault_rec_pkg::ST_COMMIT) && s.mode && (s.count < 6'h14) |=>
            s.count == $past(s.count) + 1'b1;
    endproperty
    a_alarm_store: assert property (p_alarm_store)
        else $error("fault not stored in alarms-and-trips mode");

    property p_notify;
        mem_we |=> new_fault_o && (s.nv == $past(s.cur)) && !fault_active_o;
    endproperty
    a_notify: assert property (p_notify)
        else $error("new-fault notice or fail-safe copy missing");

    property p_count_max;
        s.count <= 6'h14;
    endproperty
    a_count_max: assert property (p_count_max)
        else $error("record count above store size");

    property p_wrap;
        mem_we && (s.wr_ptr == 5'h13) |=> s.wr_ptr == 5'h00;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("write pointer did not wrap to oldest slot");

    property p_ttt_invalid;
        mem_we && (s.cur.pick_id != s.cur.trip_id) |-> !s.cur.ttt_valid;
    endproperty
    a_ttt_invalid: assert property (p_ttt_invalid)
        else $error("time to trip marked valid across modules");

    property p_snap_now;
        (s.fsm == fault_rec_pkg::ST_ACTIVE) && any_trip && !s.trip_seen && (s.dly == '0) |=>
            (s.cur.meas == $past(meas_i)) && s.cur.tripped && !s.meas_wait;
    endproperty
    a_snap_now: assert property (p_snap_now)
        else $error("snapshot not taken at trip");

    property p_snap_late;
        (s.fsm == fault_rec_pkg::ST_ACTIVE) && any_trip && !s.trip_seen && (s.dly != '0) |=>
            s.meas_wait ##1 s.meas_wait;
    endproperty
    a_snap_late: assert property (p_snap_late)
        else $error("delayed snapshot taken too early");

    c_tripped_commit: cover property (mem_we && s.cur.tripped);
    c_alarm_only: cover property (mem_we && !s.cur.tripped);
    c_delayed_snap: cover property (s.fsm == fault_rec_pkg::ST_WAIT && !s.meas_wait);
    c_wrap: cover property (mem_we && s.count == 6'h14);

endmodule // fault_event_recorder

//--- verification/prot_model.sv
// Behavioural model of the protection modules that feed the recorder
`timescale 1ns/1ps
module prot_model (
    // Clock
    input wire logic core_clk_i,
    // Towards the recorder
    output logic [7:0] pickup_o,
    output logic [7:0] trip_o,
    output logic [31:0] meas_o
);
    initial begin
        pickup_o = 8'h00;
        trip_o = 8'h00;
        meas_o = 32'h0000_00A0;
    end

    // One fault lasting len cycles; tt 0 means no trip at all.
    // The tripping module picks up too, so the pickup OR sees both modules when they differ.
    // The measurement moves 100 cycles after the trip, so early and delayed
    // snapshots give different values.
    task automatic fault(input int pm, input int tm, input int tt, input int len);
        for (int c = 0; c < len; c++) begin
            @(posedge core_clk_i);
            pickup_o[pm] <= 1'b1;
            if (tt != 0 && c == tt) begin
                trip_o[tm] <= 1'b1;
                pickup_o[tm] <= 1'b1;
            end
            if (tt != 0 && c == tt + 100) begin
                meas_o <= 32'h0000_00B1;
            end
        end
        @(posedge core_clk_i);
        pickup_o <= 8'h00;
        trip_o <= 8'h00;
        meas_o <= 32'h0000_00A0;
    endtask
endmodule // prot_model

//--- verification/fault_event_recorder_tb.sv
// Self-checking testbench of the fault event recorder
`timescale 1ns/1ps
module fault_event_recorder_tb;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ar = 1'b0, aden = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, stamp = 32'h0000_1111, prdata, q, meas;
    logic pready, pslverr, err, new_fault, active;
    logic [1:0] pset = 2'h2;
    logic [3:0] aset = 4'h9;
    logic [7:0] pickup, trip;
    int error_cnt = 0, tests_run = 0, cyc = 0;

    always #2.5 core_clk_i = ~core_clk_i;

    fault_event_recorder i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
        .pickup_i(pickup), .trip_i(trip), .auto_reclose_i(ar), .time_stamp_i(stamp),
        .param_set_i(pset), .adaptive_en_i(aden), .active_adaptive_set_i(aset),
        .meas_i(meas), .new_fault_o(new_fault), .fault_active_o(active));
    prot_model i_prot (.core_clk_i(core_clk_i), .pickup_o(pickup), .trip_o(trip),
        .meas_o(meas));

    // ----------------------------------------------------------------
    // Compare and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // Tick phase is free running, so a measured time may land one tick off
    task automatic chk_near(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (!(g === e || g === e - 1 || g === e + 1)) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do @(posedge core_clk_i); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask
    task automatic run(input int pm, input int tm, input int tt, input int len);
        fork
            i_prot.fault(pm, tm, tt, len);
            begin
                repeat (3) @(posedge core_clk_i);
                chk("fault_active", 32'h1, {31'h0, active});
            end
        join
        repeat (6) @(posedge core_clk_i);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(fault_rec_pkg::OFS_CTRL, 32'h1, "ctrl");
        rd(fault_rec_pkg::OFS_DELAY, 32'h0, "delay");
        rd(fault_rec_pkg::OFS_STATUS, 32'h0, "status");
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
    endtask
    task automatic t_trip();
        run(2, 2, 400, 1000);
        chk("active_after", 32'h0, {31'h0, active});
        chk("new_fault", 32'h1, {31'h0, new_fault});
        rd(fault_rec_pkg::OFS_STATUS, 32'h101, "status");
        rd(fault_rec_pkg::OFS_NUMBERS, 32'h0001_0001, "numbers");
        apb(1'b0, fault_rec_pkg::OFS_DURATION, 32'h0);
        chk_near("duration", 32'h5, q);
        apb(1'b0, fault_rec_pkg::OFS_TTT, 32'h0);
        chk_near("ttt", 32'h2, q);
        rd(fault_rec_pkg::OFS_INFO, 32'h0001_988B, "info");
        rd(fault_rec_pkg::OFS_MEAS, 32'hA0, "meas");
        rd(fault_rec_pkg::OFS_STAMP, 32'h1111, "stamp");
        apb(1'b1, fault_rec_pkg::OFS_STATUS, 32'h1);
        rd(fault_rec_pkg::OFS_STATUS, 32'h100, "status_clr");
    endtask
    task automatic t_cross();
        ar <= 1'b1;
        aden <= 1'b0;
        run(1, 5, 200, 600);
        ar <= 1'b0;
        rd(fault_rec_pkg::OFS_NUMBERS, 32'h0001_0002, "numbers_ar");
        rd(fault_rec_pkg::OFS_INFO, 32'h946, "info_cross");
        apb(1'b1, fault_rec_pkg::OFS_STATUS, 32'h1);
    endtask
    task automatic t_mode();
        run(3, 0, 0, 50);
        rd(fault_rec_pkg::OFS_STATUS, 32'h301, "status_alarm");
        apb(1'b0, fault_rec_pkg::OFS_INFO, 32'h0);
        chk("info_alarm", 32'hC, q & 32'h3E);
        apb(1'b1, fault_rec_pkg::OFS_STATUS, 32'h1);
        apb(1'b1, fault_rec_pkg::OFS_CTRL, 32'h0);
        run(3, 0, 0, 50);
        rd(fault_rec_pkg::OFS_STATUS, 32'h300, "status_tonly");
    endtask
    task automatic t_delay();
        apb(1'b1, fault_rec_pkg::OFS_DELAY, 32'h2);
        run(4, 4, 10, 800);
        rd(fault_rec_pkg::OFS_MEAS, 32'hB1, "meas_delayed");
        rd(fault_rec_pkg::OFS_NUMBERS, 32'h0004_0005, "numbers_d");
        // Pickup drops long before the delayed snapshot, so the commit has to wait
        run(4, 4, 10, 50);
        rd(fault_rec_pkg::OFS_STATUS, 32'h403, "status_wait");
        repeat (450) @(posedge core_clk_i);
        rd(fault_rec_pkg::OFS_STATUS, 32'h501, "status_waited");
        rd(fault_rec_pkg::OFS_NUMBERS, 32'h0005_0006, "numbers_w");
        apb(1'b1, fault_rec_pkg::OFS_DELAY, 32'h0);
    endtask
    task automatic t_fill();
        for (int i = 0; i < 17; i++) begin
            run(0, 0, 5, 20);
        end
        rd(fault_rec_pkg::OFS_STATUS, 32'h1401, "status_full");
        apb(1'b1, fault_rec_pkg::OFS_SEL, 32'd19);
        apb(1'b1, fault_rec_pkg::OFS_SEL, 32'd20);
        rd(fault_rec_pkg::OFS_SEL, 32'd19, "sel");
        apb(1'b0, fault_rec_pkg::OFS_NUMBERS, 32'h0);
        chk("oldest", 32'h3, q & 32'hFFFF);
        apb(1'b1, fault_rec_pkg::OFS_SEL, 32'h0);
        rd(fault_rec_pkg::OFS_NUMBERS, 32'h0016_0017, "newest");
    endtask

    task automatic print_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // A hang counts as a mismatch; the whole run needs well under this
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            print_verdict();
        end
    end

    initial begin
        repeat (10) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_trip();
        t_cross();
        t_mode();
        t_delay();
        t_fill();
        print_verdict();
    end
endmodule // fault_event_recorder_tb
